// File: core/pdd_pkg.sv
package pdd_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int PDD_NGEN = 4;
    localparam int PDD_AW = 8;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] PDD_OFS_CTRL = 8'h00;
    localparam logic [7:0] PDD_OFS_PERIOD = 8'h04;
    localparam logic [7:0] PDD_OFS_MDUTY = 8'h08;
    localparam logic [7:0] PDD_OFS_STATUS = 8'h0c;
    // Generator g occupies PDD_GEN_FIRST * 16 + g * 16.
    localparam logic [3:0] PDD_GEN_FIRST = 4'h1;
    localparam logic [1:0] PDD_SUB_GCTRL = 2'h0;
    localparam logic [1:0] PDD_SUB_GDUTY = 2'h1;
    localparam logic [1:0] PDD_SUB_DT = 2'h2;
    localparam logic [1:0] PDD_SUB_ALTDT = 2'h3;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int PDD_CTRL_EN_BIT = 0;
    localparam int PDD_CTRL_DEFER_BIT = 1;
    localparam int PDD_GCTRL_DTM_LSB = 0;
    localparam int PDD_GCTRL_MASTER_BIT = 2;
    localparam int PDD_GCTRL_INDEP_BIT = 3;

    // ****************************************************************
    // Reset values and special duty codes
    // ****************************************************************
    localparam logic [15:0] PDD_RST_16 = 16'h0000;
    localparam logic [15:0] PDD_DUTY_OFF = 16'h0000;
    localparam logic [15:0] PDD_DUTY_ON = 16'hffff;
    localparam logic [11:0] PDD_CNT_ZERO = 12'h000;
    localparam logic [1:0] PDD_RESP_OKAY = 2'h0;
    localparam logic [1:0] PDD_RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Timing: both steps are below one 10 ns cycle, so one count each.
    // ****************************************************************
    localparam int PDD_CLK_PS = 10000;
    localparam int PDD_TB_STEP_PS = 8400;
    localparam int PDD_DT_STEP_PS = 4160;
    localparam int PDD_TB_STEP_CYC =
        (PDD_TB_STEP_PS < PDD_CLK_PS) ? 1 : PDD_TB_STEP_PS / PDD_CLK_PS;
    localparam int PDD_DT_STEP_CYC =
        (PDD_DT_STEP_PS < PDD_CLK_PS) ? 1 : PDD_DT_STEP_PS / PDD_CLK_PS;

    // Dead-time mode codes.
    typedef enum logic [1:0] {
        PDD_DT_POS = 2'b00,
        PDD_DT_NEG = 2'b01,
        PDD_DT_OFF = 2'b10,
        PDD_DT_OFF2 = 2'b11
    } pdd_dtm_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic awvalid;
        logic [PDD_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [PDD_AW-1:0] araddr;
        logic rready;
    } pdd_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pdd_axi_rsp_t;

    typedef struct packed {
        logic [2:0] duty_lsb;
        logic dt_lsb;
    } pdd_fine_t;

endpackage

// File: core/pdd_top.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Behaviour
// - Duty 1.05 ns per LSB, period 8.4 ns.
// - Time base step equals one clock count.
// - Own duty register per generator plus master.
// - Generator may follow the master duty value.
// - Time base counter is 13 bits wide.
// - Output high while count <= duty upper 13.
// - Three duty LSBs go to fine adjust.
// - Duty writes anytime, optionally held until rollover.
// - Complementary mode drives inverted signal on low.
// - Independent mode drives same signal on both.
// - Duty 0x0008 or more gives a pulse.
// - Duty 0x0000 always low, 0xffff high.
// - Assertion waits dead time after partner drops.
// - Negative dead time forces programmed overlap.
// - Dead time disabled per generator by field.
// - 12-bit down counters fed by edge detectors.
// - Alternate dead time for the other edge.
// - Dead-time counters step per clock; LSB fine.
// - Dead time works in every output mode.
// - Four dead-time units, own values each.
// - Time base clears on period match.
// - Clearing enable clears all time bases.
module pdd_top
    import pdd_pkg::*;
(
    input wire logic clk_in,                     // Time-base clock.
    input wire logic rstn_in,                    // Async reset, low.
    input wire logic ce_in,                      // Clock enable.
    input wire pdd_axi_req_t axi_req_in,         // AXI4-Lite request.
    output pdd_axi_rsp_t axi_rsp_out,            // AXI4-Lite answer.
    output logic [PDD_NGEN-1:0] high_side_out,   // High-side pins.
    output logic [PDD_NGEN-1:0] low_side_out,    // Low-side pins.
    output pdd_fine_t [PDD_NGEN-1:0] fine_out    // Fine-adjust bits.
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0] dtm;
        logic use_master;
        logic indep;
        logic [15:0] gduty;
        logic [15:0] dt;
        logic [15:0] altdt;
        logic [15:0] act;
        logic cmp;
        logic [11:0] cnt;
        logic pend;
        logic hi;
        logic lo;
        logic lo_pin;
    } pdd_gen_t;

    typedef struct packed {
        logic en;
        logic defer;
        logic [15:0] period;
        logic [15:0] mduty;
        logic [12:0] tmr;
        pdd_gen_t [PDD_NGEN-1:0] gen;
        logic aw_got;
        logic w_got;
        logic [PDD_AW-1:0] awaddr;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        pdd_axi_rsp_t rsp;
    } pdd_state_t;

    pdd_state_t s_ff;
    pdd_state_t nxt_s;

    // Byte-lane merge for the 16-bit registers; upper lanes are unused.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] data,
                                            input logic [1:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    // True when the address hits a generator slot.
    function automatic logic gen_hit(input logic [PDD_AW-1:0] a);
        return (a[7:4] >= PDD_GEN_FIRST) &&
               (a[7:4] < PDD_GEN_FIRST + 4'(PDD_NGEN));
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // The whole block is one state vector, so the clock enable freezes
    // bus, time base and dead-time counters alike.
    always_comb begin
        logic roll;
        logic c;
        logic neg;
        logic wr;
        logic ok;
        logic [PDD_AW-1:0] ra;
        logic [31:0] rd;
        roll = 1'b0;
        c = 1'b0;
        neg = 1'b0;
        wr = 1'b0;
        ok = 1'b0;
        ra = '0;
        rd = 32'h0000_0000;
        nxt_s = s_ff;

        // Write address and data are taken in either order.
        if (axi_req_in.awvalid && s_ff.rsp.awready) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.awaddr = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && s_ff.rsp.wready) begin
            nxt_s.w_got = 1'b1;
            nxt_s.wdata = axi_req_in.wdata[15:0];
            nxt_s.wstrb = axi_req_in.wstrb[1:0];
        end
        if (s_ff.rsp.bvalid && axi_req_in.bready) begin
            nxt_s.rsp.bvalid = 1'b0;
        end

        // Perform the write once both halves are held.
        if (s_ff.aw_got && s_ff.w_got && !s_ff.rsp.bvalid) begin
            wr = 1'b1;
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.rsp.bvalid = 1'b1;
            ok = (s_ff.awaddr[1:0] == 2'b00) &&
                 ((s_ff.awaddr <= PDD_OFS_STATUS) || gen_hit(s_ff.awaddr));
            nxt_s.rsp.bresp = ok ? PDD_RESP_OKAY : PDD_RESP_SLVERR;
        end
        if (wr && ok) begin
            if (s_ff.awaddr == PDD_OFS_CTRL && s_ff.wstrb[0]) begin
                nxt_s.en = s_ff.wdata[PDD_CTRL_EN_BIT];
                nxt_s.defer = s_ff.wdata[PDD_CTRL_DEFER_BIT];
            end
            if (s_ff.awaddr == PDD_OFS_PERIOD) begin
                nxt_s.period = merge16(s_ff.period, s_ff.wdata,
                                       s_ff.wstrb);
            end
            if (s_ff.awaddr == PDD_OFS_MDUTY) begin
                nxt_s.mduty = merge16(s_ff.mduty, s_ff.wdata,
                                      s_ff.wstrb);
            end
            for (int g = 0; g < PDD_NGEN; g++) begin
                if (s_ff.awaddr[7:4] == PDD_GEN_FIRST + 4'(g)) begin
                    unique case (s_ff.awaddr[3:2])
                        PDD_SUB_GCTRL: begin
                            if (s_ff.wstrb[0]) begin
                                nxt_s.gen[g].dtm = s_ff.wdata[
                                    PDD_GCTRL_DTM_LSB +: 2];
                                nxt_s.gen[g].use_master = s_ff.wdata[
                                    PDD_GCTRL_MASTER_BIT];
                                nxt_s.gen[g].indep = s_ff.wdata[
                                    PDD_GCTRL_INDEP_BIT];
                            end
                        end
                        PDD_SUB_GDUTY: begin
                            nxt_s.gen[g].gduty = merge16(
                                s_ff.gen[g].gduty, s_ff.wdata,
                                s_ff.wstrb);
                        end
                        PDD_SUB_DT: begin
                            nxt_s.gen[g].dt = merge16(s_ff.gen[g].dt,
                                s_ff.wdata, s_ff.wstrb);
                        end
                        PDD_SUB_ALTDT: begin
                            nxt_s.gen[g].altdt = merge16(
                                s_ff.gen[g].altdt, s_ff.wdata,
                                s_ff.wstrb);
                        end
                    endcase
                end
            end
        end

        // Reads answer one cycle after the address is taken.
        if (s_ff.rsp.rvalid && axi_req_in.rready) begin
            nxt_s.rsp.rvalid = 1'b0;
        end
        if (axi_req_in.arvalid && s_ff.rsp.arready) begin
            ra = axi_req_in.araddr;
            ok = 1'b1;
            unique case (ra)
                PDD_OFS_CTRL: begin
                    rd[PDD_CTRL_EN_BIT] = s_ff.en;
                    rd[PDD_CTRL_DEFER_BIT] = s_ff.defer;
                end
                PDD_OFS_PERIOD: rd[15:0] = s_ff.period;
                PDD_OFS_MDUTY: rd[15:0] = s_ff.mduty;
                PDD_OFS_STATUS: begin
                    for (int g = 0; g < PDD_NGEN; g++) begin
                        rd[g] = s_ff.gen[g].hi;
                        rd[4 + g] = s_ff.gen[g].lo_pin;
                        rd[8 + g] = s_ff.gen[g].pend;
                    end
                    rd[12] = s_ff.en;
                end
                default: ok = (ra[1:0] == 2'b00) && gen_hit(ra);
            endcase
            for (int g = 0; g < PDD_NGEN; g++) begin
                if (ok && ra[7:4] == PDD_GEN_FIRST + 4'(g)) begin
                    unique case (ra[3:2])
                        PDD_SUB_GCTRL: begin
                            rd[PDD_GCTRL_DTM_LSB +: 2] = s_ff.gen[g].dtm;
                            rd[PDD_GCTRL_MASTER_BIT] =
                                s_ff.gen[g].use_master;
                            rd[PDD_GCTRL_INDEP_BIT] = s_ff.gen[g].indep;
                        end
                        PDD_SUB_GDUTY: rd[15:0] = s_ff.gen[g].gduty;
                        PDD_SUB_DT: rd[15:0] = s_ff.gen[g].dt;
                        PDD_SUB_ALTDT: rd[15:0] = s_ff.gen[g].altdt;
                    endcase
                end
            end
            nxt_s.rsp.rvalid = 1'b1;
            nxt_s.rsp.rdata = ok ? rd : 32'h0000_0000;
            nxt_s.rsp.rresp = ok ? PDD_RESP_OKAY : PDD_RESP_SLVERR;
        end
        // One write and one read at a time; ready drops while held.
        nxt_s.rsp.awready = !nxt_s.aw_got && !nxt_s.rsp.bvalid;
        nxt_s.rsp.wready = !nxt_s.w_got && !nxt_s.rsp.bvalid;
        nxt_s.rsp.arready = !nxt_s.rsp.rvalid;

        // Primary time base: one count per clock.
        roll = s_ff.en && (s_ff.tmr == s_ff.period[15:3]);
        if (!s_ff.en) begin
            nxt_s.tmr = 13'h0000;
        end else if (roll) begin
            nxt_s.tmr = 13'h0000;
        end else begin
            nxt_s.tmr = s_ff.tmr + 13'h0001;
        end

        // Per generator: duty select, compare and dead time.
        for (int g = 0; g < PDD_NGEN; g++) begin
            // Deferred mode keeps the old duty until the rollover.
            if (!s_ff.defer || roll) begin
                nxt_s.gen[g].act = s_ff.gen[g].use_master ?
                    s_ff.mduty : s_ff.gen[g].gduty;
            end
            if (s_ff.gen[g].act == PDD_DUTY_OFF) begin
                c = 1'b0;
            end else if (s_ff.gen[g].act == PDD_DUTY_ON) begin
                c = 1'b1;
            end else begin
                c = (s_ff.tmr <= s_ff.gen[g].act[15:3]);
            end
            neg = (s_ff.gen[g].dtm == PDD_DT_NEG);
            if (!s_ff.en) begin
                c = 1'b0;
                nxt_s.gen[g].cnt = PDD_CNT_ZERO;
                nxt_s.gen[g].pend = 1'b0;
                nxt_s.gen[g].hi = 1'b0;
                nxt_s.gen[g].lo = 1'b0;
            end else if (s_ff.gen[g].dtm[1]) begin
                // Dead time off: plain true and inverted signal.
                nxt_s.gen[g].cnt = PDD_CNT_ZERO;
                nxt_s.gen[g].pend = 1'b0;
                nxt_s.gen[g].hi = c;
                nxt_s.gen[g].lo = !c;
            end else if (c != s_ff.gen[g].cmp) begin
                // An edge restarts the counter with the value for it.
                nxt_s.gen[g].pend = 1'b1;
                nxt_s.gen[g].cnt = c ? s_ff.gen[g].dt[12:1] :
                    s_ff.gen[g].altdt[12:1];
                if (neg) begin
                    if (c) begin
                        nxt_s.gen[g].hi = 1'b1;
                    end else begin
                        nxt_s.gen[g].lo = 1'b1;
                    end
                end else begin
                    if (c) begin
                        nxt_s.gen[g].lo = 1'b0;
                    end else begin
                        nxt_s.gen[g].hi = 1'b0;
                    end
                end
            end else if (s_ff.gen[g].pend) begin
                if (s_ff.gen[g].cnt == PDD_CNT_ZERO) begin
                    nxt_s.gen[g].pend = 1'b0;
                    if (neg) begin
                        if (c) begin
                            nxt_s.gen[g].lo = 1'b0;
                        end else begin
                            nxt_s.gen[g].hi = 1'b0;
                        end
                    end else begin
                        if (c) begin
                            nxt_s.gen[g].hi = 1'b1;
                        end else begin
                            nxt_s.gen[g].lo = 1'b1;
                        end
                    end
                end else begin
                    nxt_s.gen[g].cnt = s_ff.gen[g].cnt - 12'h001;
                end
            end
            nxt_s.gen[g].cmp = c;
            // Independent mode copies the dead-timed high side.
            nxt_s.gen[g].lo_pin = s_ff.gen[g].indep ?
                nxt_s.gen[g].hi : nxt_s.gen[g].lo;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Reset leaves every pin low and every counter idle.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_ff <= '0;
        end else if (ce_in) begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Fine bits come from held registers, so they carry no glitches.
    always_comb begin
        axi_rsp_out = s_ff.rsp;
        for (int g = 0; g < PDD_NGEN; g++) begin
            high_side_out[g] = s_ff.gen[g].hi;
            low_side_out[g] = s_ff.gen[g].lo_pin;
            fine_out[g].duty_lsb = s_ff.gen[g].act[2:0];
            fine_out[g].dt_lsb = s_ff.gen[g].dt[0];
        end
    end

endmodule

// File: sim/pdd_checker_properties.sv
`timescale 1ns/10ps
module pdd_checker
    import pdd_pkg::*;
(
    input wire logic clk_in,                       // Clock.
    input wire logic rstn_in,                      // Reset, active low.
    input wire logic ce_in,                        // Clock enable.
    input wire pdd_axi_req_t axi_req_in,           // Bus request.
    input wire pdd_axi_rsp_t axi_rsp_out,          // Bus answer.
    input wire logic [PDD_NGEN-1:0] high_side_out, // High pins.
    input wire logic [PDD_NGEN-1:0] low_side_out,  // Low pins.
    input wire pdd_fine_t [PDD_NGEN-1:0] fine_out  // Fine bits.
);
    typedef struct packed {
        logic en;
        logic [PDD_NGEN-1:0][3:0] gc;
    } pdd_chk_t;
    pdd_chk_t st_ff;
    pdd_chk_t nxt_st;
    logic wr_go;

    // Shadow of enable and modes; it leads the block by one edge.
    assign wr_go = ce_in && axi_req_in.awvalid && axi_rsp_out.awready
        && axi_req_in.wvalid && axi_rsp_out.wready && axi_req_in.wstrb[0];
    always_comb begin
        nxt_st = st_ff;
        if (wr_go && axi_req_in.awaddr == PDD_OFS_CTRL) begin
            nxt_st.en = axi_req_in.wdata[PDD_CTRL_EN_BIT];
        end
        for (int g = 0; g < PDD_NGEN; g++) begin
            if (wr_go && axi_req_in.awaddr == 8'(16 + 16 * g)) begin
                nxt_st.gc[g] = axi_req_in.wdata[3:0];
            end
        end
    end

    // Cleared with the block so no stale mode survives a reset.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ********************
    // Assertions
    // ********************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    a_write_answer: assert property (
        wr_go |-> ##2 axi_rsp_out.bvalid)
        else $error("write not answered");
    a_write_done: assert property (
        axi_rsp_out.bvalid && axi_req_in.bready && ce_in
        |=> !axi_rsp_out.bvalid && axi_rsp_out.awready)
        else $error("write answer not retired");
    a_write_blocked: assert property (
        axi_rsp_out.bvalid |-> !axi_rsp_out.awready && !axi_rsp_out.wready)
        else $error("write taken while answer pending");
    a_read_answer: assert property (
        axi_req_in.arvalid && axi_rsp_out.arready && ce_in
        |=> axi_rsp_out.rvalid && axi_rsp_out.rdata[31:16] == 16'h0000)
        else $error("read not answered");
    a_read_done: assert property (
        axi_rsp_out.rvalid && axi_req_in.rready && ce_in
        |=> !axi_rsp_out.rvalid && axi_rsp_out.arready)
        else $error("read answer not retired");
    a_bad_address: assert property (
        axi_req_in.arvalid && axi_rsp_out.arready
        && axi_req_in.araddr >= 8'h50
        |=> axi_rsp_out.rresp == PDD_RESP_SLVERR
        && axi_rsp_out.rdata == 32'h0)
        else $error("unmapped read not refused");
    a_off_quiet: assert property (
        !st_ff.en [*3] |-> high_side_out == '0 && low_side_out == '0)
        else $error("pins active while disabled");

    // Per leg checks of pin relations.
    for (genvar g = 0; g < PDD_NGEN; g++) begin : gen_leg
        a_no_shoot: assert property (
            !st_ff.gc[g][3] && st_ff.gc[g][1:0] != 2'b01
            |-> !(high_side_out[g] && low_side_out[g]))
            else $error("pair overlaps without negative dead time");
        a_indep_same: assert property (
            st_ff.en && st_ff.gc[g][3]
            |-> high_side_out[g] == low_side_out[g])
            else $error("independent pair differs");
        a_comp_inverse: assert property (
            (st_ff.en && st_ff.gc[g][1] && !st_ff.gc[g][3]) [*6]
            |-> low_side_out[g] == !high_side_out[g])
            else $error("complementary pair not inverse");
    end
endmodule

bind pdd_top pdd_checker chk (.clk_in, .rstn_in, .ce_in, .axi_req_in,
    .axi_rsp_out, .high_side_out, .low_side_out, .fine_out);

// File: sim/pdd_gate_model.sv
`timescale 1ns/10ps
module pdd_gate_model
    import pdd_pkg::*;
(
    input wire logic [PDD_NGEN-1:0] high_in, // High-side gate drive.
    input wire logic [PDD_NGEN-1:0] low_in,  // Low-side gate drive.
    output logic [PDD_NGEN-1:0] shoot_out    // Leg shorts the rail.
);
    // A leg shorts the supply while both switches are on. The drivers
    // carry no delay here, so every cycle of overlap is seen in full.
    assign shoot_out = high_in & low_in;
endmodule

// File: sim/pdd_top_test.sv
`timescale 1ns/10ps
`define CHK(a, b) \
    begin \
        tests_run++; \
        if ((a) !== (b)) begin \
            err_total++; \
            $display("BAD t=%0t got=%h exp=%h", $time, a, b); \
        end \
    end
module pdd_top_test
    import pdd_pkg::*;
;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic ce_in = 1'b1;
    pdd_axi_req_t req = '0;
    pdd_axi_rsp_t rsp;
    logic [PDD_NGEN-1:0] hi;
    logic [PDD_NGEN-1:0] lo;
    logic [PDD_NGEN-1:0] shoot;
    pdd_fine_t [PDD_NGEN-1:0] fine;
    logic [31:0] rdat;
    logic [1:0] rres;
    int err_total = 0;
    int tests_run = 0;
    int hc[4];
    int lc[4];
    int sc[4];
    int same;
    int cnt;

    // Clock of 10 ns period.
    always #5 clk_in = ~clk_in;

    pdd_top uut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
        .axi_req_in(req), .axi_rsp_out(rsp), .high_side_out(hi),
        .low_side_out(lo), .fine_out(fine));
    pdd_gate_model gates (.high_in(hi), .low_in(lo), .shoot_out(shoot));

    // ********************
    // Bus and measuring tasks
    // ********************
    task test_done;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // A bounded wait that runs out counts as a mismatch.
    task stall;
        err_total++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        test_done;
    endtask

    // Address and data go out together; each is released once taken.
    task wr(input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        req.awaddr <= a;
        req.wdata <= {16'h0000, d};
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            n++;
        end while (rsp.bvalid !== 1'b1 && n < 50);
        req.bready <= 1'b0;
        if (rsp.bvalid !== 1'b1) stall;
    endtask

    task rd_reg(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk_in);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            n++;
        end while (rsp.rvalid !== 1'b1 && n < 50);
        rdat = rsp.rdata;
        rres = rsp.rresp;
        req.rready <= 1'b0;
        if (rsp.rvalid !== 1'b1) stall;
    endtask

    task chk_read(input logic [7:0] a, input logic [15:0] d,
        input logic [1:0] r);
        rd_reg(a);
        `CHK(rdat, {16'h0000, d});
        `CHK(rres, r);
    endtask

    // Counts pin-high cycles over one whole 40-count period.
    task measure;
        hc = '{0, 0, 0, 0};
        lc = '{0, 0, 0, 0};
        sc = '{0, 0, 0, 0};
        same = 0;
        repeat (40) begin
            @(negedge clk_in);
            for (int g = 0; g < PDD_NGEN; g++) begin
                hc[g] += (hi[g] === 1'b1);
                lc[g] += (lo[g] === 1'b1);
                sc[g] += (shoot[g] === 1'b1);
            end
            same += (hi[1] === lo[1]);
        end
    endtask

    task waitpin(input logic v, input int lim);
        int n;
        for (n = 0; n < lim && hi[0] !== v; n++) @(negedge clk_in);
        if (hi[0] !== v) stall;
    endtask

    task lowrun(input int n);
        cnt = 0;
        repeat (n) begin
            @(negedge clk_in);
            cnt += (hi[0] === 1'b1);
        end
    endtask

    // ********************
    // Scenarios
    // ********************
    task t_regs;
        for (int a = 0; a < 80; a += 4) begin
            chk_read(8'(a), 16'h0000, PDD_RESP_OKAY);
        end
        wr(PDD_OFS_MDUTY, 16'h1234);
        wr(8'h24, 16'habcd);
        wr(8'h48, 16'h5a5a);
        wr(8'h4c, 16'h0ff0);
        chk_read(PDD_OFS_MDUTY, 16'h1234, PDD_RESP_OKAY);
        chk_read(8'h24, 16'habcd, PDD_RESP_OKAY);
        chk_read(8'h48, 16'h5a5a, PDD_RESP_OKAY);
        chk_read(8'h4c, 16'h0ff0, PDD_RESP_OKAY);
        chk_read(8'h50, 16'h0000, PDD_RESP_SLVERR);
        chk_read(8'h06, 16'h0000, PDD_RESP_SLVERR);
        $display("regs test ended");
    endtask

    // Period of 40 counts; legs differ in pin and dead-time mode.
    task t_wave;
        logic [15:0] gc[4] = '{16'h0003, 16'h000c, 16'h0000, 16'h0001};
        logic [15:0] du[4] = '{16'h009d, 16'h0098, 16'h0098, 16'h0098};
        logic [15:0] dt[4] = '{16'h0007, 16'h0006, 16'h0006, 16'h0006};
        logic [15:0] al[4] = '{16'h0000, 16'h0000, 16'h0002, 16'h0002};
        wr(PDD_OFS_CTRL, 16'h0000);
        wr(PDD_OFS_PERIOD, 16'h0138);
        wr(PDD_OFS_MDUTY, 16'h0048);
        for (int g = 0; g < PDD_NGEN; g++) begin
            wr(8'(16 + 16 * g), gc[g]);
            wr(8'(20 + 16 * g), du[g]);
            wr(8'(24 + 16 * g), dt[g]);
            wr(8'(28 + 16 * g), al[g]);
        end
        wr(PDD_OFS_CTRL, 16'h0001);
        repeat (50) @(posedge clk_in);
        measure;
        `CHK(hc[0], 20);
        `CHK(lc[0], 20);
        `CHK(fine[0].duty_lsb, 3'h5);
        `CHK(fine[0].dt_lsb, 1'b1);
        `CHK(hc[1], 6);
        `CHK(same, 40);
        `CHK(hc[2], 16);
        `CHK(lc[2], 18);
        `CHK(sc[2], 0);
        `CHK(hc[3], 22);
        `CHK(lc[3], 24);
        `CHK(sc[3], 6);
        $display("wave test ended");
    endtask

    task t_ends;
        logic [15:0] dv[3] = '{16'h0000, 16'hffff, 16'h0008};
        int hv[3] = '{0, 40, 2};
        for (int i = 0; i < 3; i++) begin
            wr(8'h14, dv[i]);
            repeat (45) @(posedge clk_in);
            measure;
            `CHK(hc[0], hv[i]);
        end
        $display("limits test ended");
    endtask

    // A deferred duty waits for rollover; an immediate one does not.
    task t_defer;
        wr(PDD_OFS_CTRL, 16'h0003);
        wr(8'h14, 16'h0010);
        waitpin(1'b1, 100);
        waitpin(1'b0, 100);
        wr(8'h14, 16'h00f0);
        lowrun(20);
        `CHK(cnt, 0);
        waitpin(1'b1, 100);
        measure;
        `CHK(hc[0], 31);
        wr(PDD_OFS_CTRL, 16'h0001);
        waitpin(1'b0, 100);
        waitpin(1'b1, 100);
        wr(8'h14, 16'h0010);
        repeat (3) @(posedge clk_in);
        lowrun(20);
        `CHK(cnt, 0);
        $display("defer test ended");
    endtask

    task t_off;
        wr(PDD_OFS_CTRL, 16'h0000);
        repeat (3) @(posedge clk_in);
        measure;
        for (int g = 0; g < PDD_NGEN; g++) begin
            `CHK(hc[g] + lc[g], 0);
        end
        chk_read(PDD_OFS_STATUS, 16'h0000, PDD_RESP_OKAY);
        wr(PDD_OFS_CTRL, 16'h0001);
        waitpin(1'b1, 4);
        $display("disable test ended");
    endtask

    // Reset for 20 cycles, then every scenario in turn.
    initial begin
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        t_regs;
        t_wave;
        t_ends;
        t_defer;
        t_off;
        test_done;
    end
endmodule
